// ==== hw/ifr_pkg.sv ====
// package: register map, field positions and reset values of the interrupt flag register
package ifr_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] IFR_OFF_FLAGS    = 8'h95; // interrupt_flags
	localparam logic [7:0] IFR_OFF_MASK     = 8'h96; // interrupt mask, same layout
	localparam logic [7:0] IFR_OFF_PIN_FLG  = 8'h97; // per_pin_change_flags, read only
	localparam logic [7:0] IFR_OFF_PORT_FLG = 8'h98; // per_port_change_flags, read only

	// ----------------------------------------------------------------
	// field positions inside interrupt_flags
	// ----------------------------------------------------------------
	localparam int IFR_BIT_LV   = 7; // low_voltage_flag
	localparam int IFR_BIT_NVMD = 6; // nvm_write_done_flag
	localparam int IFR_BIT_BUSY = 5; // nvm_write_busy
	localparam int IFR_BIT_ADC  = 4; // conversion_done_flag
	localparam int IFR_BIT_PC   = 1; // pin_change_flag
	localparam int IFR_BIT_TMR  = 0; // third_timer_flag

	// ----------------------------------------------------------------
	// widths and reset values
	// ----------------------------------------------------------------
	localparam int IFR_DW    = 8;
	localparam int IFR_PINS  = 8;
	localparam int IFR_PORTS = 4;

	localparam logic             IFR_FLAG_RST = 1'b0;
	localparam logic [7:0]       IFR_MASK_RST = 8'h00;
	localparam logic [7:0]       IFR_RD_ZERO  = 8'h00;
	localparam logic [3:0]       IFR_PAD4     = 4'h0;
	localparam logic [1:0]       IFR_PAD2     = 2'h0;

endpackage : ifr_pkg

// ==== hw/ifr_pin_change.sv ====
// module: per-pin and per-port change flags with their summary flag
`timescale 1ns/1ps
module ifr_pin_change
	import ifr_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	input  wire logic [IFR_PINS-1:0]  pin_chg_evt,
	input  wire logic [IFR_PINS-1:0]  pin_int_en,
	input  wire logic [IFR_PORTS-1:0] port_chg_evt,
	input  wire logic [IFR_PORTS-1:0] port_int_en,
	input  wire logic                 clr_all,
	output logic [IFR_PINS-1:0]       per_pin_change_flags,
	output logic [IFR_PORTS-1:0]      per_port_change_flags,
	output logic                      pin_change_flag
);

	// ----------------------------------------------------------------
	// qualified events
	// ----------------------------------------------------------------
	// a change only counts when that source's enable is set
	wire logic [IFR_PINS-1:0]  pin_set;
	wire logic [IFR_PORTS-1:0] port_set;
	wire logic                 any_set;
	assign pin_set  = pin_chg_evt & pin_int_en;
	assign port_set = port_chg_evt & port_int_en;
	assign any_set  = |pin_set | |port_set;

	// ----------------------------------------------------------------
	// flag storage
	// ----------------------------------------------------------------
	logic [IFR_PINS-1:0]  pin_r;
	logic [IFR_PINS-1:0]  pin_nxt;
	logic [IFR_PORTS-1:0] port_r;
	logic [IFR_PORTS-1:0] port_nxt;
	logic                 pcf_r;
	logic                 pcf_nxt;

	// one clear wipes everything; a new event in the same cycle survives
	assign pin_nxt  = pin_set | (pin_r & {IFR_PINS{~clr_all}});
	assign port_nxt = port_set | (port_r & {IFR_PORTS{~clr_all}});
	assign pcf_nxt  = any_set | (pcf_r & ~clr_all);

	// state update
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_r  <= '0;
			port_r <= '0;
			pcf_r  <= IFR_FLAG_RST;
		end
		else
		begin
			pin_r  <= pin_nxt;
			port_r <= port_nxt;
			pcf_r  <= pcf_nxt;
		end
	end

	assign per_pin_change_flags  = pin_r;
	assign per_port_change_flags = port_r;
	assign pin_change_flag       = pcf_r;

endmodule : ifr_pin_change

// ==== hw/ifr_flag_reg.sv ====
// module: interrupt flag register with mask, level interrupt and register port
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module ifr_flag_reg
	import ifr_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	// register port
	input  wire logic [7:0]           addr,
	input  wire logic [IFR_DW-1:0]    wdata,
	input  wire logic                 wr_stb,
	input  wire logic                 rd_stb,
	output logic [IFR_DW-1:0]         rd_data,
	// event sources
	input  wire logic                 lv_detect,
	input  wire logic                 nvm_write_done,
	input  wire logic                 nvm_isr_enter,
	input  wire logic                 nvm_write_busy,
	input  wire logic                 adc_done,
	input  wire logic                 conversion_start_bit,
	input  wire logic [IFR_PINS-1:0]  pin_chg_evt,
	input  wire logic [IFR_PINS-1:0]  pin_int_en,
	input  wire logic [IFR_PORTS-1:0] port_chg_evt,
	input  wire logic [IFR_PORTS-1:0] port_int_en,
	input  wire logic                 third_timer_evt,
	// results
	output logic                      irq,
	output logic [IFR_PINS-1:0]       per_pin_change_flags,
	output logic [IFR_PORTS-1:0]      per_port_change_flags
);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// one compare function shared by every register select
	function automatic logic ifr_hit(input logic [7:0] a, input logic [7:0] off);
		ifr_hit = (a == off);
	endfunction : ifr_hit

	wire logic flag_wr;
	wire logic mask_wr;
	wire logic sel_flags;
	wire logic sel_mask;
	wire logic sel_pin;
	wire logic sel_port;
	assign sel_flags = ifr_hit(addr, IFR_OFF_FLAGS);
	assign sel_mask  = ifr_hit(addr, IFR_OFF_MASK);
	assign sel_pin   = ifr_hit(addr, IFR_OFF_PIN_FLG);
	assign sel_port  = ifr_hit(addr, IFR_OFF_PORT_FLG);
	assign flag_wr   = wr_stb & sel_flags;
	assign mask_wr   = wr_stb & sel_mask;

	// ----------------------------------------------------------------
	// software clear terms
	// ----------------------------------------------------------------
	// a bit written as 0 asks for a clear, a bit written as 1 is left alone,
	// so 7Fh touches only the low-voltage flag and EFh only the conversion flag
	wire logic clr_lv;
	wire logic clr_nvmd;
	wire logic clr_adc;
	wire logic clr_pc;
	wire logic clr_tmr;
	assign clr_lv   = flag_wr & ~wdata[IFR_BIT_LV] & ~lv_detect;
	assign clr_nvmd = (flag_wr & ~wdata[IFR_BIT_NVMD]) | nvm_isr_enter;
	assign clr_adc  = (flag_wr & ~wdata[IFR_BIT_ADC]) | conversion_start_bit;
	assign clr_pc   = flag_wr & ~wdata[IFR_BIT_PC];
	assign clr_tmr  = flag_wr & ~wdata[IFR_BIT_TMR];

	// ----------------------------------------------------------------
	// flag next-state
	// ----------------------------------------------------------------
	logic lv_r;
	logic lv_nxt;
	logic nvmd_r;
	logic nvmd_nxt;
	logic adc_r;
	logic adc_nxt;
	logic tmr_r;
	logic tmr_nxt;
	logic pc_flag;

	// the set term is ORed last so a coincident event is never lost
	assign lv_nxt   = lv_detect | (lv_r & ~clr_lv);
	assign nvmd_nxt = nvm_write_done | (nvmd_r & ~clr_nvmd);
	assign adc_nxt  = adc_done | (adc_r & ~clr_adc);
	assign tmr_nxt  = third_timer_evt | (tmr_r & ~clr_tmr);

	// flag storage; the supply monitor's flag also starts clear
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			lv_r   <= IFR_FLAG_RST;
			nvmd_r <= IFR_FLAG_RST;
			adc_r  <= IFR_FLAG_RST;
			tmr_r  <= IFR_FLAG_RST;
		end
		else
		begin
			lv_r   <= lv_nxt;
			nvmd_r <= nvmd_nxt;
			adc_r  <= adc_nxt;
			tmr_r  <= tmr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// pin change flags
	// ----------------------------------------------------------------
	ifr_pin_change u_pin_change (
		.clk_sys               (clk_sys),
		.rstn                  (rstn),
		.pin_chg_evt           (pin_chg_evt),
		.pin_int_en            (pin_int_en),
		.port_chg_evt          (port_chg_evt),
		.port_int_en           (port_int_en),
		.clr_all               (clr_pc),
		.per_pin_change_flags  (per_pin_change_flags),
		.per_port_change_flags (per_port_change_flags),
		.pin_change_flag       (pc_flag)
	);

	// ----------------------------------------------------------------
	// assembled flag view
	// ----------------------------------------------------------------
	// busy is taken live from the write engine, so it has no stored copy here
	wire logic [IFR_DW-1:0] flag_vec;
	wire logic [IFR_DW-1:0] irq_vec;
	logic [IFR_DW-1:0]      mask_r;
	logic                   irq_r;
	assign flag_vec = {lv_r, nvmd_r, nvm_write_busy, adc_r, IFR_PAD2, pc_flag, tmr_r};
	// busy is a state, not an event, so it never raises the interrupt
	assign irq_vec  = flag_vec & mask_r & ~(8'h01 << IFR_BIT_BUSY);

	// ----------------------------------------------------------------
	// mask register and interrupt output
	// ----------------------------------------------------------------
	// mask is plain read/write
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			mask_r <= IFR_MASK_RST;
		else if (mask_wr)
			mask_r <= wdata;
	end

	// level interrupt, registered so the output is glitch free
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			irq_r <= IFR_FLAG_RST;
		else
			irq_r <= |irq_vec;
	end
	assign irq = irq_r;

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// unmapped addresses read as zero; data stand only in the cycle after the strobe
	wire logic [IFR_DW-1:0] rd_sel;
	logic [IFR_DW-1:0]      rd_data_r;
	assign rd_sel = sel_flags ? flag_vec :
		sel_mask ? mask_r :
		sel_pin ? per_pin_change_flags :
		sel_port ? {IFR_PAD4, per_port_change_flags} : IFR_RD_ZERO;

	// read data register
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			rd_data_r <= IFR_RD_ZERO;
		else if (rd_stb)
			rd_data_r <= rd_sel;
		else
			rd_data_r <= IFR_RD_ZERO;
	end
	assign rd_data = rd_data_r;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_flag_read;
		rd_stb && sel_flags;
	endsequence

	sequence s_pc_clear;
		clr_pc && !(|(pin_chg_evt & pin_int_en)) && !(|(port_chg_evt & port_int_en));
	endsequence

	property p_lv_set;
		@(posedge clk_sys) disable iff (!rstn)
		lv_detect |=> lv_r;
	endproperty
	a_lv_set: assert property (p_lv_set)
		else $error("low-voltage flag not set by detect");

	property p_lv_clear;
		@(posedge clk_sys) disable iff (!rstn)
		(flag_wr && !wdata[IFR_BIT_LV]) |=> (lv_r == $past(lv_detect));
	endproperty
	a_lv_clear: assert property (p_lv_clear)
		else $error("low-voltage flag clear ignored supply state");

	property p_nvmd_set;
		@(posedge clk_sys) disable iff (!rstn)
		nvm_write_done |=> nvmd_r;
	endproperty
	a_nvmd_set: assert property (p_nvmd_set)
		else $error("write-done flag not set");

	property p_nvmd_isr;
		@(posedge clk_sys) disable iff (!rstn)
		(nvm_isr_enter && !nvm_write_done) |=> !nvmd_r;
	endproperty
	a_nvmd_isr: assert property (p_nvmd_isr)
		else $error("write-done flag kept after service entry");

	property p_busy_read;
		@(posedge clk_sys) disable iff (!rstn)
		s_flag_read |=> (rd_data[IFR_BIT_BUSY] == $past(nvm_write_busy));
	endproperty
	a_busy_read: assert property (p_busy_read)
		else $error("busy bit does not follow the write engine");

	property p_adc_set;
		@(posedge clk_sys) disable iff (!rstn)
		adc_done |=> adc_r ##1 (adc_r || $past(clr_adc));
	endproperty
	a_adc_set: assert property (p_adc_set)
		else $error("conversion flag not set");

	property p_adc_clear;
		@(posedge clk_sys) disable iff (!rstn)
		(conversion_start_bit || (flag_wr && !wdata[IFR_BIT_ADC])) && !adc_done |=> !adc_r;
	endproperty
	a_adc_clear: assert property (p_adc_clear)
		else $error("conversion flag not cleared");

	property p_pc_set;
		@(posedge clk_sys) disable iff (!rstn)
		|(pin_chg_evt & pin_int_en) |=> pc_flag && (per_pin_change_flags != '0);
	endproperty
	a_pc_set: assert property (p_pc_set)
		else $error("enabled pin change did not set flags");

	property p_pc_clear;
		@(posedge clk_sys) disable iff (!rstn)
		s_pc_clear |=> !pc_flag && per_pin_change_flags == '0 && per_port_change_flags == '0;
	endproperty
	a_pc_clear: assert property (p_pc_clear)
		else $error("pin change clear left a flag set");

	property p_tmr_set;
		@(posedge clk_sys) disable iff (!rstn)
		third_timer_evt |=> tmr_r;
	endproperty
	a_tmr_set: assert property (p_tmr_set)
		else $error("third timer flag not set");

	property p_keep_one;
		@(posedge clk_sys) disable iff (!rstn)
		(flag_wr && wdata[IFR_BIT_ADC] && adc_r && !conversion_start_bit) |=> adc_r;
	endproperty
	a_keep_one: assert property (p_keep_one)
		else $error("writing one cleared a flag");

	property p_irq_follow;
		@(posedge clk_sys) disable iff (!rstn)
		(|irq_vec) ##1 (|irq_vec) |-> irq;
	endproperty
	a_irq_follow: assert property (p_irq_follow)
		else $error("interrupt not raised for unmasked flag");

	property p_rd_once;
		@(posedge clk_sys) disable iff (!rstn)
		!rd_stb |=> rd_data == IFR_RD_ZERO;
	endproperty
	a_rd_once: assert property (p_rd_once)
		else $error("read data outside the answer cycle");

	property p_lv_keep;
		@(posedge clk_sys) disable iff (!rstn)
		(flag_wr && wdata[IFR_BIT_LV] && lv_r) |=> lv_r;
	endproperty
	a_lv_keep: assert property (p_lv_keep)
		else $error("writing one cleared the low-voltage flag");

	property p_nvmd_keep;
		@(posedge clk_sys) disable iff (!rstn)
		(flag_wr && wdata[IFR_BIT_NVMD] && nvmd_r && !nvm_isr_enter) |=> nvmd_r;
	endproperty
	a_nvmd_keep: assert property (p_nvmd_keep)
		else $error("writing one cleared the write-done flag");

	property p_tmr_clear;
		@(posedge clk_sys) disable iff (!rstn)
		(flag_wr && !wdata[IFR_BIT_TMR] && !third_timer_evt) |=> !tmr_r;
	endproperty
	a_tmr_clear: assert property (p_tmr_clear)
		else $error("third timer flag not cleared by a zero");

	property p_tmr_keep;
		@(posedge clk_sys) disable iff (!rstn)
		(flag_wr && wdata[IFR_BIT_TMR] && tmr_r) |=> tmr_r;
	endproperty
	a_tmr_keep: assert property (p_tmr_keep)
		else $error("writing one cleared the third timer flag");

	property p_pc_keep;
		@(posedge clk_sys) disable iff (!rstn)
		(flag_wr && wdata[IFR_BIT_PC] && pc_flag) |=> pc_flag;
	endproperty
	a_pc_keep: assert property (p_pc_keep)
		else $error("writing one cleared the pin change flag");

	// a per-pin or per-port flag may only rise where its enable stood at the event
	property p_pin_gate;
		@(posedge clk_sys) disable iff (!rstn)
		1'b1 |=>
			((per_pin_change_flags & ~$past(per_pin_change_flags) & ~$past(pin_int_en)) == '0) &&
			((per_port_change_flags & ~$past(per_port_change_flags) & ~$past(port_int_en)) == '0);
	endproperty
	a_pin_gate: assert property (p_pin_gate)
		else $error("disabled pin raised a change flag");

	property p_mask_write;
		@(posedge clk_sys) disable iff (!rstn)
		mask_wr |=> (mask_r == $past(wdata));
	endproperty
	a_mask_write: assert property (p_mask_write)
		else $error("mask write did not land");

	sequence s_adc_event;
		adc_done ##1 mask_r[IFR_BIT_ADC];
	endsequence

	property p_adc_irq;
		@(posedge clk_sys) disable iff (!rstn)
		s_adc_event |=> irq;
	endproperty
	a_adc_irq: assert property (p_adc_irq)
		else $error("unmasked conversion flag did not interrupt");

endmodule : ifr_flag_reg

// ==== dv/tb.sv ====
// testbench: self-checking scenarios for the interrupt flag register
`timescale 1ns/1ps
module tb;
	import ifr_pkg::*;

	// ----------------------------------------------------------------
	// signals and design
	// ----------------------------------------------------------------
	logic                 clk_sys;
	logic                 rstn;
	logic [7:0]           addr;
	logic [IFR_DW-1:0]    wdata;
	logic                 wr_stb;
	logic                 rd_stb;
	logic [IFR_DW-1:0]    rd_data;
	logic                 lv_detect;
	logic                 nvm_write_done;
	logic                 nvm_isr_enter;
	logic                 nvm_write_busy;
	logic                 adc_done;
	logic                 conversion_start_bit;
	logic [IFR_PINS-1:0]  pin_chg_evt;
	logic [IFR_PINS-1:0]  pin_int_en;
	logic [IFR_PORTS-1:0] port_chg_evt;
	logic [IFR_PORTS-1:0] port_int_en;
	logic                 third_timer_evt;
	logic                 irq;
	logic [IFR_PINS-1:0]  per_pin_change_flags;
	logic [IFR_PORTS-1:0] per_port_change_flags;
	int                   err_total;
	int                   cmp_count;

	ifr_flag_reg dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .lv_detect(lv_detect),
		.nvm_write_done(nvm_write_done), .nvm_isr_enter(nvm_isr_enter),
		.nvm_write_busy(nvm_write_busy), .adc_done(adc_done),
		.conversion_start_bit(conversion_start_bit), .pin_chg_evt(pin_chg_evt),
		.pin_int_en(pin_int_en), .port_chg_evt(port_chg_evt), .port_int_en(port_int_en),
		.third_timer_evt(third_timer_evt), .irq(irq),
		.per_pin_change_flags(per_pin_change_flags),
		.per_port_change_flags(per_port_change_flags));

	// 100 MHz clock
	always #5 clk_sys = ~clk_sys;

	// ----------------------------------------------------------------
	// bus and compare helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// one-cycle write strobe, released at the next edge
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		addr   <= a;
		wdata  <= v;
		wr_stb <= 1'b1;
		@(posedge clk_sys);
		wr_stb <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge clk_sys);
		rd_stb <= 1'b0;
		#1 v = rd_data;
	endtask : rd

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
		logic [7:0] v;
		rd(a, v);
		chk(v, exp, what);
	endtask : rd_chk

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		rd_chk(IFR_OFF_FLAGS, 8'h00, "flags after reset");
		rd_chk(IFR_OFF_MASK, 8'h00, "mask after reset");
		rd_chk(8'h50, 8'h00, "unmapped read");
		chk({7'h00, irq}, 8'h00, "irq after reset");
	endtask : t_reset

	// the flag must survive a clear while the supply is still low
	task automatic t_low_voltage;
		@(posedge clk_sys) lv_detect <= 1'b1;
		rd_chk(IFR_OFF_FLAGS, 8'h80, "lv set");
		wr(IFR_OFF_FLAGS, 8'h7F);
		rd_chk(IFR_OFF_FLAGS, 8'h80, "lv clear refused while low");
		@(posedge clk_sys) lv_detect <= 1'b0;
		wr(IFR_OFF_FLAGS, 8'h7F);
		rd_chk(IFR_OFF_FLAGS, 8'h00, "lv cleared");
	endtask : t_low_voltage

	task automatic t_nvm;
		@(posedge clk_sys);
		nvm_write_busy <= 1'b1;
		nvm_write_done <= 1'b1;
		@(posedge clk_sys) nvm_write_done <= 1'b0;
		rd_chk(IFR_OFF_FLAGS, 8'h60, "write done and busy");
		wr(IFR_OFF_FLAGS, 8'hDF);
		rd_chk(IFR_OFF_FLAGS, 8'h60, "busy ignores write");
		@(posedge clk_sys) nvm_isr_enter <= 1'b1;
		@(posedge clk_sys) nvm_isr_enter <= 1'b0;
		rd_chk(IFR_OFF_FLAGS, 8'h20, "done cleared on entry");
		@(posedge clk_sys) nvm_write_busy <= 1'b0;
		rd_chk(IFR_OFF_FLAGS, 8'h00, "busy follows source");
	endtask : t_nvm

	task automatic t_adc;
		@(posedge clk_sys) adc_done <= 1'b1;
		@(posedge clk_sys) adc_done <= 1'b0;
		rd_chk(IFR_OFF_FLAGS, 8'h10, "conversion done");
		wr(IFR_OFF_FLAGS, 8'hEF);
		rd_chk(IFR_OFF_FLAGS, 8'h00, "cleared by EF");
		@(posedge clk_sys) adc_done <= 1'b1;
		@(posedge clk_sys) adc_done <= 1'b0;
		@(posedge clk_sys) conversion_start_bit <= 1'b1;
		@(posedge clk_sys) conversion_start_bit <= 1'b0;
		rd_chk(IFR_OFF_FLAGS, 8'h00, "cleared by start bit");
		// event and clearing write on the same edge
		@(posedge clk_sys);
		adc_done <= 1'b1;
		addr     <= IFR_OFF_FLAGS;
		wdata    <= 8'hEF;
		wr_stb   <= 1'b1;
		@(posedge clk_sys);
		adc_done <= 1'b0;
		wr_stb   <= 1'b0;
		rd_chk(IFR_OFF_FLAGS, 8'h10, "set beats clear");
		wr(IFR_OFF_FLAGS, 8'hEF);
	endtask : t_adc

	// disabled pins must not raise anything
	task automatic t_pins;
		pin_int_en  <= 8'h0F;
		port_int_en <= 4'h3;
		@(posedge clk_sys) pin_chg_evt <= 8'hF0;
		@(posedge clk_sys) pin_chg_evt <= 8'h00;
		rd_chk(IFR_OFF_FLAGS, 8'h00, "disabled pins ignored");
		@(posedge clk_sys);
		pin_chg_evt  <= 8'h05;
		port_chg_evt <= 4'hF;
		@(posedge clk_sys);
		pin_chg_evt  <= 8'h00;
		port_chg_evt <= 4'h0;
		rd_chk(IFR_OFF_FLAGS, 8'h02, "pin change summary");
		rd_chk(IFR_OFF_PIN_FLG, 8'h05, "per pin flags");
		rd_chk(IFR_OFF_PORT_FLG, 8'h03, "per port flags");
		wr(IFR_OFF_PIN_FLG, 8'h00);
		#1 chk(per_pin_change_flags, 8'h05, "read only pin flags");
		wr(IFR_OFF_FLAGS, 8'hFD);
		#1 chk(per_pin_change_flags, 8'h00, "pin flags cleared");
		chk({4'h0, per_port_change_flags}, 8'h00, "port flags cleared");
		rd_chk(IFR_OFF_FLAGS, 8'h00, "summary cleared");
	endtask : t_pins

	task automatic t_timer;
		@(posedge clk_sys) third_timer_evt <= 1'b1;
		@(posedge clk_sys) third_timer_evt <= 1'b0;
		wr(IFR_OFF_FLAGS, 8'hFF);
		rd_chk(IFR_OFF_FLAGS, 8'h01, "ones leave flag");
		wr(IFR_OFF_FLAGS, 8'hFE);
		rd_chk(IFR_OFF_FLAGS, 8'h00, "timer cleared");
	endtask : t_timer

	task automatic t_irq;
		wr(IFR_OFF_MASK, 8'h10);
		rd_chk(IFR_OFF_MASK, 8'h10, "mask readback");
		@(posedge clk_sys) third_timer_evt <= 1'b1;
		@(posedge clk_sys) third_timer_evt <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 chk({7'h00, irq}, 8'h00, "masked flag quiet");
		@(posedge clk_sys) adc_done <= 1'b1;
		@(posedge clk_sys) adc_done <= 1'b0;
		@(posedge clk_sys);
		#1 chk({7'h00, irq}, 8'h01, "irq raised");
		wr(IFR_OFF_FLAGS, 8'hEF);
		@(posedge clk_sys);
		#1 chk({7'h00, irq}, 8'h00, "irq cleared");
		wr(IFR_OFF_FLAGS, 8'h00);
		wr(IFR_OFF_MASK, 8'h00);
	endtask : t_irq

	// busy must stay out of the interrupt; a mid-run reset drops flags, mask and irq
	task automatic t_mid_reset;
		wr(IFR_OFF_MASK, 8'h20);
		@(posedge clk_sys) nvm_write_busy <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 chk({7'h00, irq}, 8'h00, "busy raised irq");
		wr(IFR_OFF_MASK, 8'hFF);
		@(posedge clk_sys) third_timer_evt <= 1'b1;
		@(posedge clk_sys) third_timer_evt <= 1'b0;
		@(posedge clk_sys);
		#1 chk({7'h00, irq}, 8'h01, "timer irq");
		@(posedge clk_sys);
		rstn           <= 1'b0;
		nvm_write_busy <= 1'b0;
		@(posedge clk_sys);
		#1 chk({7'h00, irq}, 8'h00, "irq in reset");
		@(posedge clk_sys) rstn <= 1'b1;
		rd_chk(IFR_OFF_FLAGS, 8'h00, "flags after mid reset");
		rd_chk(IFR_OFF_MASK, 8'h00, "mask after mid reset");
		chk({7'h00, irq}, 8'h00, "irq after mid reset");
	endtask : t_mid_reset

	// ----------------------------------------------------------------
	// verdict, watchdog and main sequence
	// ----------------------------------------------------------------
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	// the scenarios need well under 1000 cycles
	initial
	begin
		#100us;
		err_total++;
		$display("wrong value at %0t: watchdog expired", $time);
		tally_and_finish();
	end

	initial
	begin
		clk_sys = 1'b0; rstn = 1'b0; addr = 8'h00; wdata = 8'h00;
		wr_stb = 1'b0; rd_stb = 1'b0; lv_detect = 1'b0; nvm_write_done = 1'b0;
		nvm_isr_enter = 1'b0; nvm_write_busy = 1'b0; adc_done = 1'b0;
		conversion_start_bit = 1'b0; pin_chg_evt = 8'h00; pin_int_en = 8'h00;
		port_chg_evt = 4'h0; port_int_en = 4'h0; third_timer_evt = 1'b0;
		err_total = 0; cmp_count = 0;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		t_reset();
		t_low_voltage();
		t_nvm();
		t_adc();
		t_pins();
		t_timer();
		t_irq();
		t_mid_reset();
		tally_and_finish();
	end

endmodule : tb
